// >>> core/gamma_buffer_pkg.sv
/*
 Constants, field positions and helper functions for the two-wire register access block of the gamma and
 common-level reference buffer.
 Assumes a single system clock domain; the serial pins are synchronised by the user of these definitions.
*/
package gamma_buffer_pkg;

	// channels and word widths
	localparam int NUM_CHAN = 9;
	localparam int LEVEL_W  = 10;
	localparam int NV_W     = 15;
	localparam int CNT_W    = 5;

	// register pointers
	localparam logic [5:0] PTR_GAMMA_FIRST = 6'h00;
	localparam logic [5:0] PTR_GAMMA_LAST  = 6'h07;
	localparam logic [5:0] PTR_COMMON      = 6'h12;
	localparam logic [5:0] PTR_REVISION    = 6'h3c;
	localparam logic [5:0] PTR_SIGNATURE   = 6'h3d;
	localparam logic [5:0] PTR_WCOUNT      = 6'h3f;
	localparam logic [5:0] PTR_OTHER_FIRST = 6'h3c;

	// channel indices
	localparam logic [3:0] CHAN_COMMON = 4'h8;
	localparam logic [3:0] CHAN_NONE   = 4'hf;

	// byte fields: pointer prefix in D7..D6, mode in D15..D14, output latch on D15
	localparam logic [1:0] PTR_PREFIX_REG = 2'h0;
	localparam logic [1:0] MODE_NV_WRITE  = 2'h1;
	localparam int         UPDATE_BIT     = 7;

	// reset and fault values
	localparam logic [LEVEL_W-1:0] LEVEL_RESET = 10'h200;
	localparam logic [LEVEL_W-1:0] LEVEL_FAULT = 10'h100;
	localparam logic [3:0]         WCODE_RESET = 4'h0;

	// identity values, arbitrary
	localparam logic [6:0]  DEV_ADDR_DEFAULT  = 7'h74;
	localparam logic [15:0] SIGNATURE_DEFAULT = 16'h5a3c;
	localparam logic [15:0] REVISION_DEFAULT  = 16'h00a5;

	// slave bit-level phases
	typedef enum logic [2:0] {ph_idle, ph_rx, ph_ack, ph_tx, ph_mack} phase_e;

	function automatic logic [3:0] chan_of(input logic [5:0] p);
		if (p <= PTR_GAMMA_LAST)
			return {1'b0, p[2:0]};
		else if (p == PTR_COMMON)
			return CHAN_COMMON;
		else
			return CHAN_NONE;
	endfunction

	// 7 goes straight to the common level so nine words cover all channels
	function automatic logic [5:0] next_ptr(input logic [5:0] p);
		return (p == PTR_GAMMA_LAST) ? PTR_COMMON : p + 6'h01;
	endfunction

	function automatic logic [3:0] count_code(input logic [CNT_W-1:0] n);
		if (n <= 5'h01)
			return 4'h0;
		else if (n >= 5'h10)
			return 4'hf;
		else
			return 4'(n - 5'h01);
	endfunction

	// hamming positions 1..14, checks at 1,2,4,8, overall parity in bit 0
	function automatic logic [LEVEL_W:0] secded_decode(input logic [NV_W-1:0] w);
		logic [3:0]         syn;
		logic [NV_W-1:0]    c;
		logic [LEVEL_W-1:0] d;
		logic               bad;
		int                 k;
		syn = 4'h0;
		for (int i = 1; i < NV_W; i++)
			if (w[i])
				syn = syn ^ 4'(i);
		c   = w;
		bad = 1'b0;
		if (^w)
		begin
			if (syn < 4'(NV_W))
				c[syn] = ~c[syn];
			else
				bad = 1'b1;
		end
		else if (syn != 4'h0)
			bad = 1'b1;
		k = 0;
		d = '0;
		for (int i = 3; i < NV_W; i++)
			if (i != 4 && i != 8)
			begin
				d[k] = c[i];
				k++;
			end
		return {bad, bad ? LEVEL_FAULT : d};
	endfunction

endpackage

// >>> core/gamma_buffer_register_access.sv
/*
 Two-wire serial slave giving access to nine 10-bit level registers, the output latch, the write-count code,
 part signature and silicon revision, plus loading of error-corrected nonvolatile words on acquire.
 Assumes scl/sda come from another domain (pins), acquire strobes come from logic on clk_sys_in, and the
 pad logic pulls sda low while sda_oe_out is high.
*/
`timescale 1ns/100ps
module gamma_buffer_register_access
	import gamma_buffer_pkg::*;
#(
	parameter logic [6:0]  DEV_ADDR  = DEV_ADDR_DEFAULT,
	parameter logic [15:0] SIGNATURE = SIGNATURE_DEFAULT,
	parameter logic [15:0] REVISION  = REVISION_DEFAULT
)
(
	// clock and reset
	input  wire logic                        clk_sys_in,
	input  wire logic                        rst_n_in,
	// serial bus pins
	input  wire logic                        scl_in,
	input  wire logic                        sda_in,
	output logic                             sda_out,
	output logic                             sda_oe_out,
	// nonvolatile contents and acquire strobes
	input  wire logic                        acq_all_in,
	input  wire logic                        acq_one_in,
	input  wire logic [3:0]                  acq_chan_in,
	input  wire logic [NUM_CHAN*NV_W-1:0]    nv_words_in,
	input  wire logic [NUM_CHAN*CNT_W-1:0]   nv_counts_in,
	// nonvolatile write request
	output logic                             nv_write_out,
	output logic [3:0]                       nv_chan_out,
	output logic [LEVEL_W-1:0]               nv_data_out,
	// latched output levels, channel 0 lowest
	output logic [NUM_CHAN*LEVEL_W-1:0]      level_out
);

	typedef struct packed {
		logic                                scl_m;
		logic                                scl_s;
		logic                                scl_d;
		logic                                sda_m;
		logic                                sda_s;
		logic                                sda_d;
		phase_e                              phase;
		logic [3:0]                          bitcnt;
		logic [7:0]                          shreg;
		logic                                first;
		logic                                rd;
		logic                                ptr_ok;
		logic                                hi_ok;
		logic                                acked;
		logic                                m_ok;
		logic                                tx_lo;
		logic [4:0]                          words;
		logic [5:0]                          ptr;
		logic [7:0]                          hi;
		logic [15:0]                         rword;
		logic [7:0]                          txbyte;
		logic                                sda_oe;
		logic [NUM_CHAN-1:0][LEVEL_W-1:0]    regs;
		logic [NUM_CHAN-1:0][LEVEL_W-1:0]    outs;
		logic [3:0]                          wcode;
		logic                                nv_we;
		logic [3:0]                          nv_chan;
		logic [LEVEL_W-1:0]                  nv_data;
	} state_s;

	state_s                               st;
	state_s                               nx;
	logic [1:0]                           rst_sync;
	logic                                 rst_n;
	logic                                 scl_rise;
	logic                                 scl_fall;
	logic                                 bus_start;
	logic                                 bus_stop;
	logic [NUM_CHAN-1:0][LEVEL_W-1:0]     dec_val;
	logic [NUM_CHAN-1:0][CNT_W-1:0]       dec_cnt;

	if (DEV_ADDR == 7'h00)
	begin : g_bad_addr
		$error("device address zero collides with general call");
	end

	// reset is released through two flops
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	// only the second synchroniser stage and its delayed copy feed decisions
	assign scl_rise  = st.scl_s & ~st.scl_d;
	assign scl_fall  = ~st.scl_s & st.scl_d;
	assign bus_start = st.scl_s & st.scl_d & st.sda_d & ~st.sda_s;
	assign bus_stop  = st.scl_s & st.scl_d & ~st.sda_d & st.sda_s;

	for (genvar i = 0; i < NUM_CHAN; i++)
	begin : g_decode
		logic unused_bad;
		assign {unused_bad, dec_val[i]} = secded_decode(nv_words_in[i*NV_W +: NV_W]);
		assign dec_cnt[i] = nv_counts_in[i*CNT_W +: CNT_W];
	end

	function automatic logic [15:0] read_word(input logic [5:0] p, input logic burst);
		logic [3:0] ch;
		ch = chan_of(p);
		if (ch != CHAN_NONE)
			return {6'h00, st.regs[ch]};
		else if (burst)
			return 16'h0000;
		else if (p == PTR_SIGNATURE)
			return SIGNATURE;
		else if (p == PTR_REVISION)
			return REVISION;
		else if (p == PTR_WCOUNT)
			return {12'h000, st.wcode};
		else
			return 16'h0000;
	endfunction

	always_comb
	begin
		logic [3:0]         ch;
		logic [LEVEL_W-1:0] val;
		logic [CNT_W-1:0]   most;
		logic [15:0]        nw;
		ch   = CHAN_NONE;
		val  = '0;
		most = '0;
		nw   = '0;
		nx   = st;
		nx.scl_m = scl_in;
		nx.scl_s = st.scl_m;
		nx.scl_d = st.scl_s;
		nx.sda_m = sda_in;
		nx.sda_s = st.sda_m;
		nx.sda_d = st.sda_s;
		nx.nv_we = 1'b0;
		if (bus_start)
		begin
			// a half-received word is dropped here
			nx.phase  = ph_rx;
			nx.bitcnt = 4'h0;
			nx.first  = 1'b1;
			nx.ptr_ok = 1'b0;
			nx.hi_ok  = 1'b0;
			nx.words  = 5'h00;
			nx.sda_oe = 1'b0;
		end
		else if (bus_stop)
		begin
			nx.phase  = ph_idle;
			nx.hi_ok  = 1'b0;
			nx.sda_oe = 1'b0;
		end
		else
			case (st.phase)
				ph_rx:
					if (scl_rise)
					begin
						nx.shreg  = {st.shreg[6:0], st.sda_s};
						nx.bitcnt = st.bitcnt + 4'h1;
					end
					else if (scl_fall && st.bitcnt == 4'h8)
					begin
						nx.bitcnt = 4'h0;
						nx.phase  = ph_ack;
						nx.acked  = 1'b1;
						if (st.first)
						begin
							nx.first = 1'b0;
							nx.rd    = st.shreg[0];
							nx.rword = read_word(st.ptr, 1'b0);
							if (st.shreg[7:1] != DEV_ADDR)
							begin
								nx.phase = ph_idle;
								nx.acked = 1'b0;
							end
						end
						else if (!st.ptr_ok)
						begin
							// read-only pointers are accepted so a read can be set up
							if (st.shreg[7:6] == PTR_PREFIX_REG && (chan_of(st.shreg[5:0]) != CHAN_NONE
								|| st.shreg[5:0] >= PTR_OTHER_FIRST))
							begin
								nx.ptr    = st.shreg[5:0];
								nx.ptr_ok = 1'b1;
							end
							else
								nx.acked = 1'b0;
						end
						else if (!st.hi_ok)
						begin
							nx.hi    = st.shreg;
							nx.hi_ok = 1'b1;
						end
						else
						begin
							nx.hi_ok = 1'b0;
							ch       = chan_of(st.ptr);
							val      = {st.hi[1:0], st.shreg};
							if (st.hi[7:6] == MODE_NV_WRITE)
							begin
								if (st.words == 5'h00 && ch != CHAN_NONE)
								begin
									nx.nv_we    = 1'b1;
									nx.nv_chan  = ch;
									nx.nv_data  = val;
									nx.regs[ch] = val;
									nx.outs[ch] = val;
								end
							end
							else
							begin
								if (ch != CHAN_NONE)
									nx.regs[ch] = val;
								if (st.hi[UPDATE_BIT])
									nx.outs = nx.regs;
							end
							nx.ptr   = next_ptr(st.ptr);
							nx.words = (st.words == 5'h1f) ? st.words : st.words + 5'h01;
						end
						nx.sda_oe = nx.acked;
					end
				ph_ack:
					if (scl_fall)
					begin
						nx.sda_oe = 1'b0;
						if (!st.acked)
							nx.phase = ph_idle;
						else if (st.rd)
						begin
							nx.phase  = ph_tx;
							nx.txbyte = st.rword[15:8];
							nx.tx_lo  = 1'b0;
							nx.sda_oe = ~st.rword[15];
						end
						else
							nx.phase = ph_rx;
					end
				ph_tx:
					if (scl_fall)
					begin
						if (st.bitcnt == 4'h7)
						begin
							nx.phase  = ph_mack;
							nx.bitcnt = 4'h0;
							nx.sda_oe = 1'b0;
						end
						else
						begin
							nx.bitcnt = st.bitcnt + 4'h1;
							nx.txbyte = {st.txbyte[6:0], 1'b0};
							nx.sda_oe = ~st.txbyte[6];
						end
					end
				ph_mack:
					if (scl_rise)
						nx.m_ok = ~st.sda_s;
					else if (scl_fall)
					begin
						if (!st.m_ok)
							nx.phase = ph_idle;
						else
						begin
							if (!st.tx_lo)
							begin
								nx.txbyte = st.rword[7:0];
								nx.tx_lo  = 1'b1;
							end
							else
							begin
								nx.ptr    = next_ptr(st.ptr);
								nw        = read_word(nx.ptr, 1'b1);
								nx.rword  = nw;
								nx.txbyte = nw[15:8];
								nx.tx_lo  = 1'b0;
								nx.words  = (st.words == 5'h1f) ? st.words : st.words + 5'h01;
							end
							nx.phase  = ph_tx;
							nx.sda_oe = ~nx.txbyte[7];
						end
					end
				default:
					nx.sda_oe = 1'b0;
			endcase
		// acquire overrides a serial write landing in the same cycle
		if (acq_all_in)
		begin
			for (int i = 0; i < NUM_CHAN; i++)
			begin
				nx.regs[i] = dec_val[i];
				nx.outs[i] = dec_val[i];
				if (dec_cnt[i] > most)
					most = dec_cnt[i];
			end
			nx.wcode = count_code(most);
		end
		else if (acq_one_in && acq_chan_in < 4'(NUM_CHAN))
		begin
			nx.regs[acq_chan_in] = dec_val[acq_chan_in];
			nx.outs[acq_chan_in] = dec_val[acq_chan_in];
			nx.wcode             = count_code(dec_cnt[acq_chan_in]);
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st       <= '0;
			st.scl_m <= 1'b1;
			st.scl_s <= 1'b1;
			st.scl_d <= 1'b1;
			st.sda_m <= 1'b1;
			st.sda_s <= 1'b1;
			st.sda_d <= 1'b1;
			st.phase <= ph_idle;
			st.regs  <= {NUM_CHAN{LEVEL_RESET}};
			st.outs  <= {NUM_CHAN{LEVEL_RESET}};
			st.wcode <= WCODE_RESET;
		end
		else
			st <= nx;
	end

	// open drain: the pad only ever pulls low
	assign sda_out      = 1'b0;
	assign sda_oe_out   = st.sda_oe;
	assign nv_write_out = st.nv_we;
	assign nv_chan_out  = st.nv_chan;
	assign nv_data_out  = st.nv_data;
	assign level_out    = st.outs;

endmodule // gamma_buffer_register_access

// >>> tb/gamma_access_chk.sv
/*
 Port assertions for the two-wire register block, attached by bind.
 Assumes sda_in is the resolved wire and scl holds each level for at least 4 clocks.
*/
`timescale 1ns/100ps
module gamma_access_chk
	import gamma_buffer_pkg::*;
(
	// clock and pins
	input wire logic                        clk_sys_in,
	input wire logic                        rst_n_in,
	input wire logic                        scl_in,
	input wire logic                        sda_in,
	input wire logic                        sda_out,
	input wire logic                        sda_oe_out,
	// acquire and results
	input wire logic                        acq_all_in,
	input wire logic                        acq_one_in,
	input wire logic [3:0]                  acq_chan_in,
	input wire logic [NUM_CHAN*NV_W-1:0]    nv_words_in,
	input wire logic                        nv_write_out,
	input wire logic [3:0]                  nv_chan_out,
	input wire logic [LEVEL_W-1:0]          nv_data_out,
	input wire logic [NUM_CHAN*LEVEL_W-1:0] level_out
);
	default clocking @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);
	// long enough for the pin syncs to drain
	sequence idle_s;
		(scl_in && sda_in && !acq_all_in && !acq_one_in)[*6];
	endsequence
	sequence scl_high_s;
		$past(scl_in, 2) && $past(scl_in, 3) && $past(scl_in, 4);
	endsequence
	pull_low_a: assert property (sda_out == 1'b0)
		else $error("sda pull value not low");
	oe_edge_a: assert property ($changed(sda_oe_out) |-> not scl_high_s)
		else $error("sda drive moved while scl high");
	nv_pulse_a: assert property (nv_write_out |=> !nv_write_out)
		else $error("nv write pulse too long");
	nv_hold_a: assert property ($changed({nv_chan_out, nv_data_out}) |-> nv_write_out)
		else $error("nv request moved without pulse");
	// an acquire in the same cycle wins, so it is left out here
	nv_level_a: assert property (nv_write_out && !$past(acq_all_in || acq_one_in)
		|-> level_out[nv_chan_out*LEVEL_W +: LEVEL_W] == nv_data_out) else $error("nv write not shown on level");
	idle_hold_a: assert property (idle_s |=> $stable(level_out))
		else $error("levels moved on idle bus");
	acq_clean_a: assert property (acq_all_in && nv_words_in[14:0] == 15'h0000 |=> level_out[9:0] == 10'h000)
		else $error("clean word not loaded");
	acq_fault_a: assert property (acq_all_in && nv_words_in[14:0] == 15'h0003 |=> level_out[9:0] == 10'h100)
		else $error("double error not replaced");
	acq_one_a: assert property (acq_one_in && acq_chan_in == 4'h8 && nv_words_in[134:120] == 15'h0000
		|=> level_out[89:80] == 10'h000) else $error("single acquire not loaded");
endmodule // gamma_access_chk

bind gamma_buffer_register_access gamma_access_chk u_chk (.clk_sys_in, .rst_n_in, .scl_in, .sda_in, .sda_out,
	.sda_oe_out, .acq_all_in, .acq_one_in, .acq_chan_in, .nv_words_in, .nv_write_out, .nv_chan_out,
	.nv_data_out, .level_out);

// >>> tb/serial_master_model.sv
/*
 Behavioural two-wire bus master: drives scl, pulls sda low.
 Assumes sda_in is the wire with pull-up; one bit takes 8 clocks.
*/
`timescale 1ns/100ps
module serial_master_model
(
	// clock
	input  wire logic clk_sys_in,
	// bus
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_low_out
);
	initial
	begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask
	// sampled mid high phase, well clear of the slave's drive change
	task automatic bit_io(input logic b, output logic r);
		sda_low_out <= ~b;
		wait_clk(2);
		scl_out <= 1'b1;
		wait_clk(2);
		r = sda_in;
		wait_clk(2);
		scl_out <= 1'b0;
		wait_clk(2);
	endtask
	// also a repeated start; waits for the ack release first
	task automatic start_c;
		sda_low_out <= 1'b0;
		wait_clk(4);
		scl_out <= 1'b1;
		wait_clk(4);
		sda_low_out <= 1'b1;
		wait_clk(4);
		scl_out <= 1'b0;
		wait_clk(2);
	endtask
	task automatic stop_c;
		sda_low_out <= 1'b1;
		wait_clk(4);
		scl_out <= 1'b1;
		wait_clk(4);
		sda_low_out <= 1'b0;
		wait_clk(8);
	endtask
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic rd_byte(output logic [7:0] d, input logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(~ack, r);
	endtask
endmodule // serial_master_model

// >>> tb/testbench.sv
/*
 Self-checking bench for the two-wire register block.
 Assumes the master model in serial_master_model and a pull-up on sda.
*/
`timescale 1ns/100ps
module testbench
	import gamma_buffer_pkg::*;
;
	localparam logic [6:0]  ADDR = 7'h2c;
	localparam logic [15:0] SIG  = 16'h1e87; // arbitrary
	localparam logic [15:0] REV  = 16'h0003; // arbitrary
	logic                        clk_sys   = 1'b0;
	logic                        rst_n     = 1'b0;
	logic                        acq_all   = 1'b0;
	logic                        acq_one   = 1'b0;
	logic [3:0]                  acq_chan  = 4'h0;
	logic [NUM_CHAN*NV_W-1:0]    nv_words  = '0;
	logic [NUM_CHAN*CNT_W-1:0]   nv_counts = '0;
	logic                        scl, sda_low, sda_oe, sda_pull, nv_wr;
	logic [3:0]                  nv_chan;
	logic [LEVEL_W-1:0]          nv_data;
	logic [NUM_CHAN*LEVEL_W-1:0] level;
	logic [15:0]                 wv [0:9];
	logic [15:0]                 rv [0:1];
	logic [LEVEL_W-1:0]          exp_lv [0:8];
	int                          error_cnt = 0;
	int                          comparisons = 0;
	int                          nv_pulses = 0;
	wire sda_line = !(sda_low || (sda_oe && !sda_pull));
	always #20 clk_sys = ~clk_sys;
	gamma_buffer_register_access #(.DEV_ADDR(ADDR), .SIGNATURE(SIG), .REVISION(REV)) DUT (
		.clk_sys_in(clk_sys), .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_pull),
		.sda_oe_out(sda_oe), .acq_all_in(acq_all), .acq_one_in(acq_one), .acq_chan_in(acq_chan),
		.nv_words_in(nv_words), .nv_counts_in(nv_counts), .nv_write_out(nv_wr), .nv_chan_out(nv_chan),
		.nv_data_out(nv_data), .level_out(level));
	serial_master_model master (.clk_sys_in(clk_sys), .sda_in(sda_line), .scl_out(scl), .sda_low_out(sda_low));
	// counts cycles with the nonvolatile request high, so a stuck or missing pulse shows
	always @(posedge clk_sys)
		if (nv_wr === 1'b1)
			nv_pulses <= nv_pulses + 1;
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		comparisons++;
		if (s !== e)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic chk_lv;
		for (int i = 0; i < 9; i++)
			chk("level", {6'h00, exp_lv[i]}, {6'h00, level[i*10+:10]});
	endtask
	task automatic wb(input logic [7:0] d, input logic e);
		logic a;
		master.wr_byte(d, a);
		chk("ack", {15'h0000, e}, {15'h0000, a});
	endtask
	// a set lone bit sends only the high byte of word n
	task automatic wr(input logic [5:0] p, input int n, input logic lone);
		master.start_c();
		wb({ADDR, 1'b0}, 1'b1);
		wb({2'b00, p}, 1'b1);
		for (int i = 0; i < n; i++)
		begin
			wb(wv[i][15:8], 1'b1);
			wb(wv[i][7:0], 1'b1);
		end
		if (lone)
			wb(wv[n][15:8], 1'b1);
		master.stop_c();
	endtask
	task automatic rd(input logic [5:0] p, input int n);
		logic [7:0] h;
		logic [7:0] l;
		master.start_c();
		wb({ADDR, 1'b0}, 1'b1);
		wb({2'b00, p}, 1'b1);
		master.start_c();
		wb({ADDR, 1'b1}, 1'b1);
		for (int i = 0; i < n; i++)
		begin
			master.rd_byte(h, 1'b1);
			master.rd_byte(l, i < n - 1);
			rv[i] = {h, l};
		end
		master.stop_c();
	endtask
	function automatic logic [14:0] enc(input logic [9:0] d);
		logic [14:0] w;
		logic [3:0]  s;
		int          k;
		w = '0;
		s = 4'h0;
		k = 0;
		for (int i = 3; i < 15; i++)
			if (i != 4 && i != 8)
			begin
				w[i] = d[k];
				k++;
			end
		for (int i = 3; i < 15; i++)
			if (w[i])
				s = s ^ 4'(i);
		{w[8], w[4], w[2], w[1]} = s;
		w[0] = ^w[14:1];
		return w;
	endfunction
	task automatic pulse(input logic a, input logic [3:0] c);
		@(posedge clk_sys);
		acq_all <= a;
		acq_one <= !a;
		acq_chan <= c;
		@(posedge clk_sys);
		acq_all <= 1'b0;
		acq_one <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic reset_values;
		for (int i = 0; i < 9; i++)
			exp_lv[i] = 10'h200;
		chk_lv();
		rd(PTR_GAMMA_FIRST, 1);
		chk("ch0", 16'h0200, rv[0]);
	endtask
	task automatic burst_write;
		for (int i = 0; i < 9; i++)
		begin
			exp_lv[i] = 10'(i * 113 + 5);
			wv[i] = {6'h00, exp_lv[i]};
		end
		wv[8][15] = 1'b1;
		wv[9] = 16'h03ff;
		wr(PTR_GAMMA_FIRST, 10, 1'b0);
		chk_lv();
	endtask
	task automatic partial_write;
		wv[0] = 16'h01ff;
		wv[1] = 16'h8200;
		wr(6'h01, 1, 1'b1);
		chk_lv();
		rd(PTR_GAMMA_LAST, 2);
		chk("ch7", {6'h00, exp_lv[7]}, rv[0]);
		chk("common", {6'h00, exp_lv[8]}, rv[1]);
		rd(6'h01, 1);
		chk("ch1", 16'h01ff, rv[0]);
		rd(6'h02, 1);
		chk("ch2", {6'h00, exp_lv[2]}, rv[0]);
	endtask
	task automatic copy_all;
		wv[0] = 16'h82aa;
		wr(PTR_COMMON, 1, 1'b0);
		exp_lv[1] = 10'h1ff;
		exp_lv[8] = 10'h2aa;
		chk_lv();
	endtask
	task automatic ident_regs;
		wv[0] = 16'h0123;
		wr(PTR_SIGNATURE, 1, 1'b0);
		rd(PTR_SIGNATURE, 1);
		chk("signature", SIG, rv[0]);
		rd(PTR_REVISION, 1);
		chk("revision", REV, rv[0]);
		rd(PTR_WCOUNT, 1);
		chk("code", 16'h0000, rv[0]);
	endtask
	task automatic refusals;
		master.start_c();
		wb({7'h2d, 1'b0}, 1'b0);
		master.stop_c();
		master.start_c();
		wb({ADDR, 1'b0}, 1'b1);
		wb(8'h08, 1'b0);
		master.stop_c();
		master.start_c();
		wb({ADDR, 1'b0}, 1'b1);
		wb(8'h41, 1'b0);
		master.stop_c();
	endtask
	task automatic nv_write;
		wv[0] = 16'h41a5;
		wr(6'h04, 1, 1'b0);
		chk("nv pulses", 16'h0001, 16'(nv_pulses));
		chk("nv chan", 16'h0004, {12'h000, nv_chan});
		chk("nv data", 16'h01a5, {6'h00, nv_data});
		exp_lv[4] = 10'h1a5;
		chk_lv();
	endtask
	task automatic acquire;
		logic [NUM_CHAN*NV_W-1:0] w;
		for (int i = 3; i < 9; i++)
		begin
			exp_lv[i] = 10'(i * 37);
			w[i*15+:15] = enc(exp_lv[i]);
		end
		w[44:0] = {enc(10'h155) ^ 15'h0006, enc(10'h2b5) ^ 15'h0020, 15'h0000};
		exp_lv[0] = 10'h000;
		exp_lv[1] = 10'h2b5;
		exp_lv[2] = 10'h100;
		nv_words <= w;
		nv_counts <= {5'h00, 5'h00, 5'h00, 5'h03, 5'h00, 5'h10, 15'h0000};
		pulse(1'b1, 4'h0);
		chk_lv();
		rd(PTR_WCOUNT, 1);
		chk("code", 16'h000f, rv[0]);
		w[14:0] = 15'h0003;
		exp_lv[0] = 10'h100;
		nv_words <= w;
		nv_counts <= {9{5'h01}};
		pulse(1'b1, 4'h0);
		chk_lv();
		rd(PTR_WCOUNT, 1);
		chk("code", 16'h0000, rv[0]);
		w[134:120] = 15'h0000;
		exp_lv[8] = 10'h000;
		nv_words <= w;
		nv_counts[44:40] <= 5'h05;
		pulse(1'b0, 4'h8);
		chk_lv();
		rd(PTR_WCOUNT, 1);
		chk("code", 16'h0004, rv[0]);
		// a serial write at the code's pointer must leave it alone
		wv[0] = 16'h0009;
		wr(PTR_WCOUNT, 1, 1'b0);
		rd(PTR_WCOUNT, 1);
		chk("code", 16'h0004, rv[0]);
		chk("nv pulses", 16'h0001, 16'(nv_pulses));
	endtask
	task automatic end_sim;
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk_sys);
		reset_values();
		burst_write();
		partial_write();
		copy_all();
		ident_regs();
		refusals();
		nv_write();
		acquire();
		end_sim();
	end
endmodule // testbench
